// ==== hw/sector_protection_logic.sv ====
// Sector protection logic: guard bits, freeze bit, password unlock and
// AXI4-Lite register slave. Assumes software issues one command at a time
// and the flash array executes granted requests.
// Summary of operation
// RL1 - One persistent bit per group of sectors; boot sectors own one each.
// RL2 - Erase clears all persistent bits together; program sets one bit.
// RL3 - Host must program every persistent bit before erasing them.
// RL4 - Single freeze bit; set blocks persistent bit changes, clear allows.
// RL5 - Persistent mode: reset clears freeze; no command clears it.
// RL6 - One volatile bit per sector, zero at reset, freely written.
// RL7 - Sector protected when its persistent or volatile bit is set.
// RL8 - Freeze set rejects program and erase of persistent bits.
// RL9 - Guard pin low blocks changes to the two outermost high boot sectors.
// RL10 - Volatile bits change regardless of the freeze bit.
// RL11 - Program to protected sector ignored; status about 1 us.
// RL12 - Erase to protected sector ignored; status about 50 us.
// RL13 - Verify command returns volatile, persistent and freeze bits.
// RL14 - Persistent-mode lock set refuses password-mode lock programming.
// RL15 - Password mode sets freeze at reset; reset here also clears pw_lock, so freeze ends up clear.
// RL16 - Unlock compares 64-bit password; match clears freeze, else nothing.
// RL17 - Each password compare takes a fixed 2 us.
// RL18 - Password-mode lock blocks all access to the stored password.
// RL19 - Persistent mode ignores the unlock command.
// RL20 - Password-mode lock refuses persistent-mode lock programming.
// RL21 - Neither lock bit set behaves as persistent mode.
`timescale 1ns/10ps
module sector_protection_logic #(
  parameter int PROG_REJ_CYC = guard_pkg::PROG_REJ_CYC,
  parameter int ERASE_REJ_CYC = guard_pkg::ERASE_REJ_CYC,
  parameter int PW_DELAY_CYC = guard_pkg::PW_DELAY_CYC,
  parameter int NSEC = guard_pkg::NUM_SECTORS,
  parameter int NGRP = guard_pkg::NUM_GROUPS
) (
  input wire logic ref_clk,            // 200 MHz clock
  input wire logic rst,                // Asynchronous reset, high
  input wire logic write_guard_n,      // Write-guard pin, low protects
  input wire logic [31:0] s_awaddr,    // AXI write address
  input wire logic s_awvalid,          // AXI write address valid
  output logic s_awready,              // AXI write address ready
  input wire logic [31:0] s_wdata,     // AXI write data
  input wire logic [3:0] s_wstrb,      // AXI write strobes
  input wire logic s_wvalid,           // AXI write data valid
  output logic s_wready,               // AXI write data ready
  output logic [1:0] s_bresp,          // AXI write response
  output logic s_bvalid,               // AXI write response valid
  input wire logic s_bready,           // AXI write response ready
  input wire logic [31:0] s_araddr,    // AXI read address
  input wire logic s_arvalid,          // AXI read address valid
  output logic s_arready,              // AXI read address ready
  output logic [31:0] s_rdata,         // AXI read data
  output logic [1:0] s_rresp,          // AXI read response
  output logic s_rvalid,               // AXI read response valid
  input wire logic s_rready,           // AXI read response ready
  output guard_pkg::array_req_t array_req, // Granted array operation
  output logic reject_busy             // Rejected command status window
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REJ = 3'b010,
    ST_PWCHK = 3'b100
  } eng_t;

  typedef struct packed {
    // Guard storage
    logic [NGRP-1:0] persistent_guard_bit;
    logic [NSEC-1:0] volatile_guard_bit;
    logic guard_freeze_bit;
    logic pers_lock;
    logic pw_lock;
    logic [63:0] pw_store;
    // Engine
    eng_t eng;
    logic [guard_pkg::CNT_W-1:0] cnt;
    logic rejected;
    logic granted;
    logic unlock_ok;
    guard_pkg::array_req_t req;
    logic [2:0] verify;
    logic [63:0] pw_in;
    logic [31:0] pw_rd;
    // Bus
    logic aw_hold;
    logic w_hold;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic init;
  } prot_state_t;

  prot_state_t s_r, s_nxt;

  logic [guard_pkg::SEC_W-1:0] cmd_sector;
  logic [guard_pkg::GRP_W-1:0] cmd_group;
  logic [3:0] cmd_op;
  logic cmd_val;
  logic wr_fire;
  logic pw_start;
  logic pw_done;
  logic pw_match;
  logic [2:0] wg_sync_r;
  logic wg_low_r;

  // Byte-lane merge for write data
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Write-guard pin synchroniser; level accepted once stages two and three agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wg_sync_r <= 3'b111;
      wg_low_r <= 1'b0;
    end else begin
      wg_sync_r <= {wg_sync_r[1:0], write_guard_n};
      if (wg_sync_r[2] == wg_sync_r[1]) begin
        wg_low_r <= ~wg_sync_r[2];
      end
    end
  end

  // Command fields from the captured write data
  assign cmd_op = s_r.wdata[guard_pkg::CMD_OP_LSB +: guard_pkg::CMD_OP_W];
  assign cmd_sector = s_r.wdata[guard_pkg::CMD_SEC_LSB +: guard_pkg::SEC_W];
  assign cmd_val = s_r.wdata[guard_pkg::CMD_VAL_BIT];
  assign wr_fire = s_r.aw_hold && s_r.w_hold && !s_r.bvalid;
  assign pw_start = wr_fire && s_r.awaddr == guard_pkg::OFS_CMD &&
                    cmd_op == guard_pkg::OP_UNLOCK && s_r.pw_lock &&
                    s_r.eng == ST_IDLE;

  sector_group_map u_map (
    .sector(cmd_sector),
    .group_idx(cmd_group)
  );

  pw_compare #(.DELAY_CYC(PW_DELAY_CYC)) u_pw (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(pw_start),
    .supplied(s_r.pw_in),
    .stored(s_r.pw_store),
    .done(pw_done),
    .match(pw_match)
  );

  // Protection of a sector: guard bits OR'd, plus the write-guard pin
  function automatic logic sec_protected(input prot_state_t st,
                                         input logic [5:0] sec,
                                         input logic [4:0] grp,
                                         input logic wg_low);
    logic p;
    p = st.persistent_guard_bit[grp] | st.volatile_guard_bit[sec]; // [RL7]
    if (wg_low && (sec == 6'(guard_pkg::WP_SEC_A) ||
                   sec == 6'(guard_pkg::WP_SEC_B))) begin
      p = 1'b1; // [RL9]
    end
    return p;
  endfunction

  // Next-state logic: bus slave, command engine, guard storage
  always_comb begin
    s_nxt = s_r;
    s_nxt.req.valid = 1'b0;
    s_nxt.init = 1'b0;
    // Freeze state after reset follows the mode
    if (s_r.init) begin
      s_nxt.guard_freeze_bit = s_r.pw_lock; // [RL5] [RL15] [RL21]
    end
    // Write address and data accepted in either order
    if (s_awvalid && !s_r.aw_hold) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.awaddr = s_awaddr[7:0];
    end
    if (s_wvalid && !s_r.w_hold) begin
      s_nxt.w_hold = 1'b1;
      s_nxt.wdata = s_wdata;
      s_nxt.wstrb = s_wstrb;
    end
    if (s_r.bvalid && s_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // Engine timers
    case (s_r.eng)
      ST_IDLE: begin
      end
      ST_REJ: begin
        if (s_r.cnt == '0) begin
          s_nxt.eng = ST_IDLE; // [RL11] [RL12]
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      ST_PWCHK: begin
        if (pw_done) begin
          s_nxt.eng = ST_IDLE;
          s_nxt.unlock_ok = pw_match;
          if (pw_match) begin
            s_nxt.guard_freeze_bit = 1'b0; // [RL16]
          end
        end
      end
      default: s_nxt.eng = ST_IDLE;
    endcase
    // Write completes
    if (wr_fire) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = guard_pkg::RESP_OKAY;
      case (s_r.awaddr)
        guard_pkg::OFS_CMD: begin
          if (s_r.eng != ST_IDLE) begin
            s_nxt.bresp = guard_pkg::RESP_SLVERR;
          end else begin
            s_nxt.rejected = 1'b0;
            s_nxt.granted = 1'b0;
            case (cmd_op)
              guard_pkg::OP_PROG, guard_pkg::OP_ERASE: begin
                if (sec_protected(s_r, cmd_sector, cmd_group, wg_low_r)) begin
                  s_nxt.rejected = 1'b1;
                  s_nxt.eng = ST_REJ;
                  s_nxt.cnt = (cmd_op == guard_pkg::OP_PROG) ?
                    guard_pkg::CNT_W'(PROG_REJ_CYC - 1) :    // [RL11]
                    guard_pkg::CNT_W'(ERASE_REJ_CYC - 1);    // [RL12]
                end else begin
                  s_nxt.granted = 1'b1;
                  s_nxt.req.valid = 1'b1;
                  s_nxt.req.erase = (cmd_op == guard_pkg::OP_ERASE);
                  s_nxt.req.sector = cmd_sector;
                end
              end
              guard_pkg::OP_VOL_WR: begin
                s_nxt.volatile_guard_bit[cmd_sector] = cmd_val; // [RL6] [RL10]
              end
              guard_pkg::OP_PER_PROG: begin
                if (s_r.guard_freeze_bit) begin
                  s_nxt.rejected = 1'b1; // [RL8] [RL4]
                end else begin
                  s_nxt.persistent_guard_bit[cmd_group] = 1'b1; // [RL1] [RL2]
                end
              end
              guard_pkg::OP_PER_ERASE: begin
                if (s_r.guard_freeze_bit) begin
                  s_nxt.rejected = 1'b1; // [RL8] [RL4]
                end else begin
                  s_nxt.persistent_guard_bit = '0; // [RL2]
                end
              end
              guard_pkg::OP_FREEZE: begin
                s_nxt.guard_freeze_bit = 1'b1; // [RL4]
              end
              guard_pkg::OP_VERIFY: begin
                s_nxt.verify[guard_pkg::VF_VOL] =
                  s_r.volatile_guard_bit[cmd_sector]; // [RL13]
                s_nxt.verify[guard_pkg::VF_PER] =
                  s_r.persistent_guard_bit[cmd_group]; // [RL13]
                s_nxt.verify[guard_pkg::VF_FRZ] = s_r.guard_freeze_bit;
              end
              guard_pkg::OP_UNLOCK: begin
                if (s_r.pw_lock) begin
                  s_nxt.eng = ST_PWCHK; // [RL17]
                  s_nxt.unlock_ok = 1'b0;
                end
                // Persistent mode: command ignored [RL19]
              end
              guard_pkg::OP_PW_PROG: begin
                if (s_r.pw_lock) begin
                  s_nxt.rejected = 1'b1; // [RL18]
                end else begin
                  s_nxt.pw_store = s_r.pw_in;
                end
              end
              guard_pkg::OP_PW_READ: begin
                if (s_r.pw_lock) begin
                  s_nxt.rejected = 1'b1; // [RL18]
                  s_nxt.pw_rd = '0;
                end else begin
                  s_nxt.pw_rd = cmd_val ? s_r.pw_store[63:32] :
                                          s_r.pw_store[31:0];
                end
              end
              guard_pkg::OP_SET_PERS: begin
                if (s_r.pw_lock) begin
                  s_nxt.rejected = 1'b1; // [RL20]
                end else begin
                  s_nxt.pers_lock = 1'b1;
                end
              end
              guard_pkg::OP_SET_PWMODE: begin
                if (s_r.pers_lock) begin
                  s_nxt.rejected = 1'b1; // [RL14]
                end else begin
                  s_nxt.pw_lock = 1'b1;
                end
              end
              default: begin
              end
            endcase
          end
        end
        guard_pkg::OFS_PW_LO: begin
          s_nxt.pw_in[31:0] = merge(s_r.pw_in[31:0], s_r.wdata, s_r.wstrb);
        end
        guard_pkg::OFS_PW_HI: begin
          s_nxt.pw_in[63:32] = merge(s_r.pw_in[63:32], s_r.wdata, s_r.wstrb);
        end
        guard_pkg::OFS_STATUS, guard_pkg::OFS_VERIFY,
        guard_pkg::OFS_MODE: begin
        end
        default: s_nxt.bresp = guard_pkg::RESP_SLVERR;
      endcase
    end
    // Read channel: one-cycle answer
    if (s_r.rvalid && s_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = guard_pkg::RESP_OKAY;
      s_nxt.rdata = '0;
      case (s_araddr[7:0])
        guard_pkg::OFS_STATUS: begin
          s_nxt.rdata[guard_pkg::ST_BUSY] = (s_r.eng != ST_IDLE);
          s_nxt.rdata[guard_pkg::ST_REJECT] = s_r.rejected;
          s_nxt.rdata[guard_pkg::ST_FREEZE] = s_r.guard_freeze_bit;
          s_nxt.rdata[guard_pkg::ST_PERS_LOCK] = s_r.pers_lock;
          s_nxt.rdata[guard_pkg::ST_PW_LOCK] = s_r.pw_lock;
          s_nxt.rdata[guard_pkg::ST_GRANT] = s_r.granted;
          s_nxt.rdata[guard_pkg::ST_UNLOCK_OK] = s_r.unlock_ok;
        end
        guard_pkg::OFS_VERIFY: s_nxt.rdata = {29'h0, s_r.verify};
        guard_pkg::OFS_MODE: s_nxt.rdata = s_r.pw_rd;
        guard_pkg::OFS_CMD, guard_pkg::OFS_PW_LO, guard_pkg::OFS_PW_HI: begin
        end
        default: s_nxt.rresp = guard_pkg::RESP_SLVERR;
      endcase
    end
  end

  // State register; non-volatile bits modelled as reset-cleared storage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.eng <= ST_IDLE;
      s_r.guard_freeze_bit <= 1'b1;
      s_r.init <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Bus handshakes and outputs
  assign s_awready = !s_r.aw_hold;
  assign s_wready = !s_r.w_hold;
  assign s_bvalid = s_r.bvalid;
  assign s_bresp = s_r.bresp;
  assign s_arready = !s_r.rvalid;
  assign s_rvalid = s_r.rvalid;
  assign s_rresp = s_r.rresp;
  assign s_rdata = s_r.rdata;
  assign array_req = s_r.req;
  assign reject_busy = (s_r.eng == ST_REJ);

endmodule

// ==== hw/guard_pkg.sv ====
// Package for the sector protection logic: register map, fields, timings.
// Assumes a 200 MHz ref_clk and an AXI4-Lite register slave.
package guard_pkg;

  // Sector layout: 8 boot + 30 main + 8 boot sectors
  localparam int NUM_SECTORS = 46;
  localparam int NUM_GROUPS = 26;
  localparam int SEC_W = 6;
  localparam int GRP_W = 5;
  localparam int WP_SEC_A = 44;
  localparam int WP_SEC_B = 45;
  localparam int BOOT_LO_LAST = 7;
  localparam int BOOT_HI_FIRST = 38;

  // Timing
  localparam int CLK_MHZ = 200;
  localparam int PROG_REJ_NS = 1000;
  localparam int ERASE_REJ_NS = 50000;
  localparam int PW_DELAY_NS = 2000;
  localparam int NS_PER_US = 1000;
  localparam int PROG_REJ_CYC = PROG_REJ_NS * CLK_MHZ / NS_PER_US;
  localparam int ERASE_REJ_CYC = ERASE_REJ_NS * CLK_MHZ / NS_PER_US;
  localparam int PW_DELAY_CYC = PW_DELAY_NS * CLK_MHZ / NS_PER_US;
  localparam int CNT_W = 16;

  // Register byte addresses
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_VERIFY = 8'h08;
  localparam logic [7:0] OFS_PW_LO = 8'h0c;
  localparam logic [7:0] OFS_PW_HI = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;

  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 4;
  localparam int CMD_SEC_LSB = 8;
  localparam int CMD_VAL_BIT = 16;

  // Command codes
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_PROG = 4'h1;
  localparam logic [3:0] OP_ERASE = 4'h2;
  localparam logic [3:0] OP_VOL_WR = 4'h3;
  localparam logic [3:0] OP_PER_PROG = 4'h4;
  localparam logic [3:0] OP_PER_ERASE = 4'h5;
  localparam logic [3:0] OP_FREEZE = 4'h6;
  localparam logic [3:0] OP_VERIFY = 4'h7;
  localparam logic [3:0] OP_UNLOCK = 4'h8;
  localparam logic [3:0] OP_PW_PROG = 4'h9;
  localparam logic [3:0] OP_PW_READ = 4'ha;
  localparam logic [3:0] OP_SET_PERS = 4'hb;
  localparam logic [3:0] OP_SET_PWMODE = 4'hc;

  // Status register bits
  localparam int ST_BUSY = 0;
  localparam int ST_REJECT = 1;
  localparam int ST_FREEZE = 2;
  localparam int ST_PERS_LOCK = 3;
  localparam int ST_PW_LOCK = 4;
  localparam int ST_GRANT = 5;
  localparam int ST_UNLOCK_OK = 6;

  // Verify register bits
  localparam int VF_VOL = 0;
  localparam int VF_PER = 1;
  localparam int VF_FRZ = 2;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Carrier from the command engine to the array
  typedef struct packed {
    logic valid;
    logic erase;
    logic [SEC_W-1:0] sector;
  } array_req_t;

endpackage

// ==== hw/sector_group_map.sv ====
// Maps a sector number onto its persistent guard bit index.
// Assumes the fixed boot / main layout held in the package.
`timescale 1ns/10ps
module sector_group_map (
  input wire logic [guard_pkg::SEC_W-1:0] sector, // Sector number
  output logic [guard_pkg::GRP_W-1:0] group_idx   // Guard bit index
);

  // Boot sectors own a bit each; main sectors share one per group of three
  always_comb begin
    if (sector <= guard_pkg::SEC_W'(guard_pkg::BOOT_LO_LAST)) begin
      group_idx = guard_pkg::GRP_W'(sector); // [RL1]
    end else if (sector >= guard_pkg::SEC_W'(guard_pkg::BOOT_HI_FIRST)) begin
      group_idx = guard_pkg::GRP_W'(sector - 6'd20); // [RL1]
    end else begin
      group_idx = guard_pkg::GRP_W'((sector - 6'd8) / 6'd3 + 6'd8); // [RL1]
    end
  end

endmodule

// ==== hw/pw_compare.sv ====
// Password comparison with a fixed settle delay before the verdict.
// Assumes start is a one-cycle pulse and not repeated while busy.
`timescale 1ns/10ps
module pw_compare #(
  parameter int DELAY_CYC = guard_pkg::PW_DELAY_CYC
) (
  input wire logic ref_clk,         // 200 MHz clock
  input wire logic rst,             // Asynchronous reset
  input wire logic start,           // Start compare pulse
  input wire logic [63:0] supplied, // Password given
  input wire logic [63:0] stored,   // Password held
  output logic done,                // Verdict pulse
  output logic match                // Verdict, valid with done
);

  typedef struct packed {
    logic busy;
    logic hit;
    logic done;
    logic [guard_pkg::CNT_W-1:0] cnt;
  } cmp_state_t;

  cmp_state_t s_r, s_nxt;

  // Latch result at start, release it after the fixed delay
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (start && !s_r.busy) begin
      s_nxt.busy = 1'b1;
      s_nxt.hit = (supplied == stored); // [RL16]
      s_nxt.cnt = guard_pkg::CNT_W'(DELAY_CYC - 1);
    end else if (s_r.busy) begin
      if (s_r.cnt == '0) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1; // [RL17]
      end else begin
        s_nxt.cnt = s_r.cnt - 1'b1; // [RL17]
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done = s_r.done;
  assign match = s_r.hit;

endmodule

// ==== sim/array_model.sv ====
// Flash array stand-in: counts grants, keeps the last sector.
// Assumes grants arrive as one-cycle pulses on the request carrier.
`timescale 1ns/10ps
module array_model (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset, high
  input wire guard_pkg::array_req_t req, // Granted operation
  output int grants, // Grants seen
  output logic [5:0] last_sec // Last sector granted
);
  // Grant bookkeeping
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      grants <= 0;
      last_sec <= 6'h00;
    end else if (req.valid) begin
      grants <= grants + 1;
      last_sec <= req.sector;
    end
  end
endmodule

// ==== sim/sector_protection_chk.sv ====
// Port checker for the sector protection logic.
// Assumes the bind below and one clock domain.
`timescale 1ns/10ps
module sector_protection_chk #(
  parameter int PROG_REJ_CYC = 4,
  parameter int ERASE_REJ_CYC = 8
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic write_guard_n, // Guard pin
  input wire logic s_awvalid, // AW valid
  input wire logic s_awready, // AW ready
  input wire logic s_wvalid, // W valid
  input wire logic s_wready, // W ready
  input wire logic s_bvalid, // B valid
  input wire logic s_bready, // B ready
  input wire logic [1:0] s_bresp, // B response
  input wire logic s_arvalid, // AR valid
  input wire logic s_arready, // AR ready
  input wire logic s_rvalid, // R valid
  input wire logic s_rready, // R ready
  input wire logic [31:0] s_rdata, // R data
  input wire guard_pkg::array_req_t array_req, // Grant
  input wire logic reject_busy // Reject window
);
  localparam int REJ_MAX = ERASE_REJ_CYC + 2;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Handshake and grant relations
  grant_pulse_a: assert property (array_req.valid |=> !array_req.valid)
    else $error("grant longer than one cycle");
  guard_pin_a: assert property (!write_guard_n [*6] |->
    !(array_req.valid && array_req.sector >= 6'd44))
    else $error("guarded sector granted");
  reject_grant_a: assert property (reject_busy |-> !array_req.valid)
    else $error("grant during reject window");
  reject_min_a: assert property ($rose(reject_busy) |-> reject_busy [*4])
    else $error("reject window too short");
  reject_max_a: assert property ($rose(reject_busy) |->
    ##[PROG_REJ_CYC:REJ_MAX] !reject_busy)
    else $error("reject window too long");
  bresp_hold_a: assert property (s_bvalid && !s_bready |=>
    s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_rvalid && !s_rready |=>
    s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  aw_block_a: assert property (s_awvalid && s_awready |=> !s_awready)
    else $error("write address taken twice");
  read_lat_a: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  write_lat_a: assert property (s_awvalid && s_awready && s_wvalid &&
    s_wready |-> ##[1:2] s_bvalid)
    else $error("write answer late");
endmodule
bind sector_protection_logic sector_protection_chk #(
  .PROG_REJ_CYC(PROG_REJ_CYC), .ERASE_REJ_CYC(ERASE_REJ_CYC)) i_chk (
  .ref_clk, .rst, .write_guard_n, .s_awvalid, .s_awready, .s_wvalid,
  .s_wready, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready,
  .s_rvalid, .s_rready, .s_rdata, .array_req, .reject_busy);

// ==== sim/sector_protection_logic_bench.sv ====
// Self-checking bench for the sector protection logic over AXI4-Lite.
// Assumes the array model and the bound checker alongside.
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("Error at %0t: got %h want %h", $time, a, e); end end
module sector_protection_logic_bench;
  logic ref_clk, rst, write_guard_n, reject_busy;
  logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, st, d;
  logic [3:0] s_wstrb;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [1:0] s_bresp, s_rresp, resp;
  logic [5:0] last_sec;
  guard_pkg::array_req_t array_req;
  int errors, n_checks, grants, c0;
  localparam int FRZ = guard_pkg::ST_FREEZE;
  sector_protection_logic #(.PROG_REJ_CYC(4), .ERASE_REJ_CYC(8),
    .PW_DELAY_CYC(4)) i_sector_protection_logic (.ref_clk, .rst,
    .write_guard_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .array_req, .reject_busy);
  array_model i_array_model (.ref_clk, .rst, .req(array_req), .grants,
    .last_sec);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task conclude;
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task do_reset;
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
  endtask
  // One write; address and data each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] r);
    logic da, dw;
    {da, dw} = 2'b00;
    @(posedge ref_clk);
    s_awaddr <= {24'h0, a};
    s_wdata <= dd;
    {s_awvalid, s_wvalid, s_bready} <= 3'b111;
    do begin
      @(negedge ref_clk);
      da = da | s_awready;
      dw = dw | s_wready;
      @(posedge ref_clk);
      if (da) s_awvalid <= 1'b0;
      if (dw) s_wvalid <= 1'b0;
    end while (!(da && dw));
    do @(negedge ref_clk); while (s_bvalid !== 1'b1);
    r = s_bresp;
    @(posedge ref_clk);
    s_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    logic t;
    @(posedge ref_clk);
    s_araddr <= {24'h0, a};
    {s_arvalid, s_rready} <= 2'b11;
    do begin
      @(negedge ref_clk);
      t = s_arready;
      @(posedge ref_clk);
    end while (!t);
    s_arvalid <= 1'b0;
    do @(negedge ref_clk); while (s_rvalid !== 1'b1);
    q = s_rdata;
    r = s_rresp;
    @(posedge ref_clk);
    s_rready <= 1'b0;
  endtask
  // Poll status until idle
  task idle;
    int n;
    n = 0;
    do begin
      rd(8'h04, st, resp);
      n++;
    end while ((st[guard_pkg::ST_BUSY] | reject_busy) !== 1'b0 && n < 50);
    `CHK(n < 50, 1'b1)
  endtask
  task cmd(input logic [3:0] op, input logic [5:0] sec, input logic v);
    wr(8'h00, {15'h0, v, 2'h0, sec, 4'h0, op}, resp);
    idle;
  endtask
  task vfy(input logic [5:0] sec, input logic [2:0] e);
    cmd(guard_pkg::OP_VERIFY, sec, 1'b0);
    rd(8'h08, d, resp);
    `CHK(d[2:0], e)
  endtask
  task t_reset;
    rd(8'h04, st, resp);
    `CHK(st[FRZ], 1'b0)
    `CHK(st[4:3], 2'b00)
    vfy(6'd0, 3'b000);
    rd(8'h20, d, resp);
    `CHK(resp, guard_pkg::RESP_SLVERR)
  endtask
  task t_volatile;
    cmd(guard_pkg::OP_VOL_WR, 6'd5, 1'b1);
    c0 = grants;
    cmd(guard_pkg::OP_PROG, 6'd5, 1'b0);
    `CHK(st[guard_pkg::ST_REJECT], 1'b1)
    `CHK(grants, c0)
    wr(8'h00, {18'h0, 6'd5, 4'h0, guard_pkg::OP_ERASE}, resp);
    wr(8'h00, 32'h0, resp);
    `CHK(resp, guard_pkg::RESP_SLVERR)
    idle;
    `CHK(grants, c0)
    cmd(guard_pkg::OP_VOL_WR, 6'd5, 1'b0);
    cmd(guard_pkg::OP_PROG, 6'd5, 1'b0);
    `CHK(grants, c0 + 1)
    `CHK(last_sec, 6'd5)
  endtask
  task t_persist;
    c0 = grants;
    cmd(guard_pkg::OP_PER_PROG, 6'd9, 1'b0);
    vfy(6'd10, 3'b010);
    vfy(6'd11, 3'b000);
    cmd(guard_pkg::OP_PER_PROG, 6'd38, 1'b0);
    vfy(6'd32, 3'b000);
    cmd(guard_pkg::OP_ERASE, 6'd8, 1'b0);
    `CHK(grants, c0)
    for (int s = 0; s < guard_pkg::NUM_SECTORS; s++)
      cmd(guard_pkg::OP_PER_PROG, s[5:0], 1'b0);
    cmd(guard_pkg::OP_PER_ERASE, 6'd0, 1'b0);
    vfy(6'd45, 3'b000);
    vfy(6'd9, 3'b000);
  endtask
  task t_freeze;
    cmd(guard_pkg::OP_FREEZE, 6'd0, 1'b0);
    cmd(guard_pkg::OP_PER_PROG, 6'd20, 1'b0);
    vfy(6'd20, 3'b100);
    cmd(guard_pkg::OP_VOL_WR, 6'd20, 1'b1);
    vfy(6'd20, 3'b101);
    cmd(guard_pkg::OP_UNLOCK, 6'd0, 1'b0);
    `CHK(st[FRZ], 1'b1)
    do_reset;
    rd(8'h04, st, resp);
    `CHK(st[FRZ], 1'b0)
    vfy(6'd20, 3'b000);
  endtask
  task t_guard;
    write_guard_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    c0 = grants;
    cmd(guard_pkg::OP_PROG, 6'd45, 1'b0);
    `CHK(grants, c0)
    cmd(guard_pkg::OP_PROG, 6'd43, 1'b0);
    `CHK(grants, c0 + 1)
    write_guard_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    cmd(guard_pkg::OP_PROG, 6'd44, 1'b0);
    `CHK(grants, c0 + 2)
  endtask
  task t_modes;
    cmd(guard_pkg::OP_SET_PERS, 6'd0, 1'b0);
    cmd(guard_pkg::OP_SET_PWMODE, 6'd0, 1'b0);
    `CHK(st[4:3], 2'b01)
    do_reset;
    wr(8'h0c, 32'h1234_5678, resp);
    wr(8'h10, 32'h9abc_def0, resp);
    cmd(guard_pkg::OP_PW_PROG, 6'd0, 1'b0);
    cmd(guard_pkg::OP_PW_READ, 6'd0, 1'b0);
    rd(8'h14, d, resp);
    `CHK(d, 32'h1234_5678)
    cmd(guard_pkg::OP_SET_PWMODE, 6'd0, 1'b0);
    cmd(guard_pkg::OP_SET_PERS, 6'd0, 1'b0);
    `CHK(st[4:3], 2'b10)
    cmd(guard_pkg::OP_PW_READ, 6'd0, 1'b1);
    rd(8'h14, d, resp);
    `CHK(d, 32'h0)
    cmd(guard_pkg::OP_FREEZE, 6'd0, 1'b0);
    wr(8'h0c, 32'h0, resp);
    cmd(guard_pkg::OP_UNLOCK, 6'd0, 1'b0);
    `CHK(st[FRZ], 1'b1)
    wr(8'h0c, 32'h1234_5678, resp);
    wr(8'h00, {28'h0, guard_pkg::OP_UNLOCK}, resp);
    rd(8'h04, st, resp);
    `CHK(st[guard_pkg::ST_BUSY], 1'b1)
    idle;
    `CHK(st[FRZ], 1'b0)
    `CHK(st[guard_pkg::ST_UNLOCK_OK], 1'b1)
  endtask
  // Watchdog
  initial begin
    #200000;
    errors++;
    conclude;
  end
  // Main sequence
  initial begin
    {errors, n_checks} = '0;
    {rst, write_guard_n} = 2'b11;
    {s_awaddr, s_wdata, s_araddr} = '0;
    s_wstrb = 4'hf;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    do_reset;
    t_reset;
    t_volatile;
    t_persist;
    t_freeze;
    t_guard;
    t_modes;
    conclude;
  end
endmodule
